// *** common/sws_pkg.sv ***
// Shared constants and types for the service window supervisor.
package sws_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] SWS_SVC_OFS = 8'h00;
  localparam logic [7:0] SWS_CTRL_OFS = 8'h04;
  localparam logic [7:0] SWS_STAT_OFS = 8'h08;

  // Field positions inside the service register.
  localparam int SWS_WIN_MSB = 7;
  localparam int SWS_WIN_LSB = 6;
  localparam int SWS_KEY_MSB = 5;
  localparam int SWS_KEY_LSB = 1;
  localparam int SWS_CM_BIT = 0;

  // Field positions inside the control and status registers.
  localparam int SWS_CTRL_CLK_DELAY_BIT = 0;
  localparam int SWS_STAT_PEND_BIT = 0;
  localparam int SWS_STAT_WDFLT_BIT = 1;
  localparam int SWS_STAT_CMERR_BIT = 2;
  localparam int SWS_STAT_CFG_BIT = 3;
  localparam int SWS_STAT_DRIVE_BIT = 4;

  // Values after reset and the fixed service key.
  localparam logic [1:0] SWS_WIN_RESET = 2'h3;
  localparam logic SWS_CM_EN_RESET = 1'b1;
  localparam logic SWS_CLK_DELAY_RESET = 1'b0;
  localparam logic [4:0] SWS_SVC_KEY = 5'h0C;

  // Window limits and idle timer, counted in instruction cycles.
  localparam int SWS_LOWER_LIMIT = 2048;
  localparam int SWS_BASE_UPPER = 8192;
  localparam int SWS_IDLE_BITS = 13;
  localparam int SWS_IDLE_TOGGLE_BIT = 12;

  // Pin hold after the pin is seen low, in instruction cycles.
  localparam int SWS_HOLD_MIN = 16;
  localparam int SWS_HOLD_MAX = 32;
  localparam int SWS_HOLD_DEFAULT = 24;

  // Clock monitor frequencies in hertz.
  localparam int SWS_CM_REJECT_HZ = 10;
  localparam int SWS_CM_ACCEPT_HZ = 10000;
  localparam int SWS_REF_TICK_HZ = 1000;

  // Fault pin sequencer states.
  typedef enum logic [3:0] {
    SWS_FLT_IDLE = 4'h1,
    SWS_FLT_DRIVE = 4'h2,
    SWS_FLT_HOLD = 4'h4,
    SWS_FLT_WAIT = 4'h8
  } sws_fault_e;

endpackage

// *** core/sws_supervisor.sv ***
// Windowed program supervisor with clock monitor and idle timer behind an APB slave.
//
// Behaviour
// R1 - Supervisor and monitor quiet during reset.
// R2 - Reset arms longest window, monitor enabled.
// R3 - First keyed write fixes window and monitor.
// R4 - Later writes must match key, window, monitor.
// R5 - Missing service before upper limit is error.
// R6 - Service before 2048 cycles is error.
// R7 - First configuring write restarts the window.
// R8 - Initial service may come early without error.
// R9 - Fault pin active low, else released.
// R10 - Drive low, hold 16-32 cycles after seen low.
// R11 - Window restarts when pin returns high.
// R12 - Services ignored while pin driven low.
// R13 - Clock error drives pin, releases after recovery.
// R14 - Accept 10 kHz clocks, reject below 10 Hz.
// R15 - Key field always reads as zero.
// R16 - Supervision timer paused in halt and idle.
// R17 - Clock monitor keeps running in halt, idle.
// R18 - Halt exit resumes or restarts by oscillator option.
// R19 - Idle exit is an automatic service.
// R20 - Idle timer flag every 4096 cycles, software clears.
// R21 - Window bits pick 8k, 16k, 32k, 64k.
// R22 - Service key is 01100.
// R23 - Clock check uses independent reference ticks.
//
// The APB register port and the address map were left to the implementer.
module sws_supervisor
  import sws_pkg::*;
#(
  parameter int HOLD_CYCLES = SWS_HOLD_DEFAULT,
  parameter int REF_TICK_HZ = SWS_REF_TICK_HZ
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic inst_tick_i,
  input wire logic ref_tick_i,
  input wire logic halt_i,
  input wire logic idle_i,
  input wire logic rc_osc_opt_i,
  input wire logic fault_pin_i,
  output logic fault_pin_o,
  output logic fault_pin_oe_n_o,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);

  // Reference ticks allowed between instruction cycles before the clock is rejected.
  localparam int CM_LIMIT = REF_TICK_HZ / (2 * SWS_CM_REJECT_HZ);

  // Refuse parameter values the counters cannot serve.
  // A hold outside 16 to 32 ticks breaks the pin timing, and a monitor limit under two
  // reference ticks would trip on the phase of the reference alone.
  initial begin
    if (HOLD_CYCLES < SWS_HOLD_MIN || HOLD_CYCLES > SWS_HOLD_MAX) begin
      $error("HOLD_CYCLES must lie between 16 and 32.");
    end
    if (CM_LIMIT < 2 || CM_LIMIT > 65535 || REF_TICK_HZ > 2 * SWS_CM_ACCEPT_HZ) begin
      $error("REF_TICK_HZ does not give a usable clock monitor limit.");
    end
  end

  // Last counter value of the selected window.
  // The shift gives 8k, 16k, 32k or 64k ticks, so the last value always fits 16 bits.
  function automatic logic [15:0] last_cycle(input logic [1:0] win);
    return 16'((SWS_BASE_UPPER << win) - 1);
  endfunction

  // Register file, bus and supervisor state.
  // Each group has its next value computed in one combinational process and a
  // register that only stores it.
  logic [1:0] win_reg, win_next;
  logic cm_en_reg, cm_en_next;
  logic cfg_reg, cfg_next;
  logic clk_delay_reg, clk_delay_next;
  logic pend_reg, pend_next;
  logic [15:0] wd_cnt_reg, wd_cnt_next;
  logic first_win_reg, first_win_next;
  sws_fault_e flt_reg, flt_next;
  logic [5:0] hold_cnt_reg, hold_cnt_next;
  logic halt_d_reg, halt_d_next;
  logic idle_d_reg, idle_d_next;
  logic [15:0] cm_cnt_reg, cm_cnt_next;
  logic cm_err_reg, cm_err_next;
  logic cm_hold_reg, cm_hold_next;
  logic [5:0] cm_hcnt_reg, cm_hcnt_next;
  logic drive_reg, drive_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [SWS_IDLE_BITS-1:0] idle_cnt_reg = '0;
  logic [SWS_IDLE_BITS-1:0] idle_cnt_next;

  logic acc_done;
  logic wr_svc, wr_ctrl, wr_stat;
  logic [7:0] wbyte;
  logic key_ok, win_ok, cm_ok;

  // Bus decode: a write takes effect at the edge where pready is sampled high.
  // Decoding on the registered ready keeps a write from landing twice, and the
  // master still holds address and data at that edge, so nothing is latched early.
  // Only the low byte of the write data is used; the upper bytes are ignored.
  always_comb begin
    acc_done = psel_i & penable_i & pready_reg;
    wr_svc = acc_done & pwrite_i & (paddr_i == SWS_SVC_OFS);
    wr_ctrl = acc_done & pwrite_i & (paddr_i == SWS_CTRL_OFS);
    wr_stat = acc_done & pwrite_i & (paddr_i == SWS_STAT_OFS);
    wbyte = pwdata_i[7:0];
    key_ok = (wbyte[SWS_KEY_MSB:SWS_KEY_LSB] == SWS_SVC_KEY); // see R22
    win_ok = (wbyte[SWS_WIN_MSB:SWS_WIN_LSB] == win_reg);
    cm_ok = (wbyte[SWS_CM_BIT] == cm_en_reg);
  end

  // APB answer: one wait state, read data and error registered together.
  // The key bits of the service register always read as zero, so software cannot
  // learn the key by reading the register back.
  always_comb begin
    pready_next = psel_i & penable_i & ~pready_reg;
    pslverr_next = 1'b0;
    prdata_next = 32'h0000_0000;
    if (psel_i & penable_i & ~pready_reg) begin
      case (paddr_i)
        SWS_SVC_OFS: begin
          prdata_next[SWS_WIN_MSB:SWS_WIN_LSB] = win_reg;
          prdata_next[SWS_CM_BIT] = cm_en_reg; // see R15
        end
        SWS_CTRL_OFS: begin
          prdata_next[SWS_CTRL_CLK_DELAY_BIT] = clk_delay_reg;
        end
        SWS_STAT_OFS: begin
          prdata_next[SWS_STAT_PEND_BIT] = pend_reg;
          prdata_next[SWS_STAT_WDFLT_BIT] = (flt_reg != SWS_FLT_IDLE);
          prdata_next[SWS_STAT_CMERR_BIT] = cm_err_reg;
          prdata_next[SWS_STAT_CFG_BIT] = cfg_reg;
          prdata_next[SWS_STAT_DRIVE_BIT] = drive_reg;
        end
        default: begin
          // Unmapped addresses answer with an error and read as zero.
          pslverr_next = 1'b1;
        end
      endcase
    end
  end

  // Supervision timer, configuration and fault pin sequencer.
  // The window counter counts instruction ticks since the last restart. Until the
  // first restart after reset the early check is waived, so the configuring write
  // may come at any time inside the longest window. Errors only start the sequencer
  // from its quiet state; while it runs, further errors and services have no effect.
  // A restart clears the counter and ends the waiver for good.
  always_comb begin
    logic svc_ok;
    logic err_evt;
    logic restart;
    svc_ok = 1'b0;
    err_evt = 1'b0;
    restart = 1'b0;
    win_next = win_reg;
    cm_en_next = cm_en_reg;
    cfg_next = cfg_reg;
    wd_cnt_next = wd_cnt_reg;
    first_win_next = first_win_reg;
    flt_next = flt_reg;
    hold_cnt_next = hold_cnt_reg;
    // The delay select is a plain control bit that only steers the halt exit.
    clk_delay_next = wr_ctrl ? wbyte[SWS_CTRL_CLK_DELAY_BIT] : clk_delay_reg;
    // Service writes count only while the sequencer is quiet and the pin is free.
    if (wr_svc && flt_reg == SWS_FLT_IDLE && !drive_reg) begin // see R12
      if (!cfg_reg) begin
        if (key_ok) begin
          win_next = wbyte[SWS_WIN_MSB:SWS_WIN_LSB]; // see R3
          cm_en_next = wbyte[SWS_CM_BIT];
          cfg_next = 1'b1;
          svc_ok = 1'b1; // see R7
        end else begin
          // A first write with the wrong key leaves the block unconfigured.
          err_evt = 1'b1;
        end
      end else if (!(key_ok && win_ok && cm_ok)) begin
        // A later write must repeat the stored window and monitor bit with the key.
        err_evt = 1'b1; // see R4
      end else if (!first_win_reg && wd_cnt_reg < 16'(SWS_LOWER_LIMIT)) begin
        err_evt = 1'b1; // see R6
      end else begin
        svc_ok = 1'b1; // see R8
      end
    end
    if (flt_reg == SWS_FLT_IDLE) begin
      if (svc_ok) begin
        restart = 1'b1;
      end else if (idle_d_reg && !idle_i) begin
        restart = 1'b1; // see R19
      end else if (halt_d_reg && !halt_i) begin
        // Only the RC option with no start-up delay keeps the count across halt.
        if (!(rc_osc_opt_i && !clk_delay_reg)) begin
          restart = 1'b1; // see R18
        end
      end else if (inst_tick_i && !halt_i && !idle_i) begin // see R16
        if (wd_cnt_reg == last_cycle(win_reg)) begin
          err_evt = 1'b1; // see R5 R21
        end else begin
          wd_cnt_next = wd_cnt_reg + 16'h0001;
        end
      end
    end
    if (restart) begin
      wd_cnt_next = 16'h0000;
      first_win_next = 1'b0;
    end
    // Fault pin sequencer: drive, wait for low, hold, release, wait for high.
    // The hold starts only once the pin is seen low, so a slow pull-down still gets
    // the full hold time; a pin kept low from outside waits in the last state.
    case (flt_reg)
      SWS_FLT_IDLE: begin
        if (err_evt) begin
          flt_next = SWS_FLT_DRIVE; // see R10
        end
      end
      SWS_FLT_DRIVE: begin
        hold_cnt_next = 6'h00;
        if (!fault_pin_i) begin
          flt_next = SWS_FLT_HOLD;
        end
      end
      SWS_FLT_HOLD: begin
        if (inst_tick_i) begin
          if (hold_cnt_reg == 6'(HOLD_CYCLES - 1)) begin
            flt_next = SWS_FLT_WAIT; // see R10
          end else begin
            hold_cnt_next = hold_cnt_reg + 6'h01;
          end
        end
      end
      SWS_FLT_WAIT: begin
        if (fault_pin_i) begin
          flt_next = SWS_FLT_IDLE;
          wd_cnt_next = 16'h0000; // see R11
          first_win_next = 1'b0;
        end
      end
      default: begin
        flt_next = SWS_FLT_IDLE;
      end
    endcase
  end

  // Clock monitor on independent reference ticks, running in halt and idle too.
  // The counter restarts on every instruction tick and saturates at the limit, so a
  // stopped instruction clock is reported however long it stays stopped. Clearing the
  // enable at configuration drops a pending error and its hold at once.
  always_comb begin
    cm_cnt_next = cm_cnt_reg;
    cm_err_next = cm_err_reg;
    cm_hold_next = cm_hold_reg;
    cm_hcnt_next = cm_hcnt_reg;
    if (inst_tick_i) begin // see R17
      cm_cnt_next = 16'h0000;
    end else if (ref_tick_i && cm_cnt_reg != 16'(CM_LIMIT)) begin // see R23
      cm_cnt_next = cm_cnt_reg + 16'h0001;
    end
    if (!cm_en_reg) begin
      cm_err_next = 1'b0;
      cm_hold_next = 1'b0;
    end else if (cm_cnt_reg == 16'(CM_LIMIT)) begin
      cm_err_next = 1'b1; // see R14
      cm_hold_next = 1'b0;
    end else if (cm_err_reg && inst_tick_i) begin
      cm_err_next = 1'b0; // see R13
      cm_hold_next = 1'b1;
      cm_hcnt_next = 6'h00;
    end else if (cm_hold_reg && inst_tick_i) begin
      if (cm_hcnt_reg == 6'(HOLD_CYCLES - 1)) begin
        cm_hold_next = 1'b0; // see R13
      end else begin
        cm_hcnt_next = cm_hcnt_reg + 6'h01;
      end
    end
  end

  // Pin drive combines both error sources; idle timer flag sets over a clear.
  // The drive is taken from the next state so that the pin follows an error at once.
  // Set wins over a clear in the same cycle, so a toggle is never lost.
  always_comb begin
    logic [SWS_IDLE_BITS-1:0] nxt;
    nxt = idle_cnt_reg + SWS_IDLE_BITS'(1);
    idle_cnt_next = inst_tick_i ? nxt : idle_cnt_reg;
    drive_next = (flt_next == SWS_FLT_DRIVE) | (flt_next == SWS_FLT_HOLD) |
                 cm_err_next | cm_hold_next; // see R9
    pend_next = pend_reg;
    if (wr_stat && wbyte[SWS_STAT_PEND_BIT]) begin
      pend_next = 1'b0;
    end
    if (inst_tick_i && (nxt[SWS_IDLE_TOGGLE_BIT] != idle_cnt_reg[SWS_IDLE_TOGGLE_BIT])) begin
      pend_next = 1'b1; // see R20
    end
  end

  // Idle timer keeps running through reset.
  // It has no reset branch on purpose: software syncs to its free-running count.
  // The declaration value only gives simulation a known start.
  always_ff @(posedge mclk_i) begin
    idle_cnt_reg <= idle_cnt_next; // see R20
  end

  // Mode levels delayed by one cycle, so that leaving halt or idle shows as an edge.
  always_comb begin
    halt_d_next = halt_i;
    idle_d_next = idle_i;
  end

  // State registers with synchronous reset.
  // The delayed mode levels reset to the idle level of their inputs, so no false
  // exit edge follows reset.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      win_reg <= SWS_WIN_RESET; // see R2
      cm_en_reg <= SWS_CM_EN_RESET;
      cfg_reg <= 1'b0;
      clk_delay_reg <= SWS_CLK_DELAY_RESET;
      pend_reg <= 1'b0;
      wd_cnt_reg <= 16'h0000;
      first_win_reg <= 1'b1;
      flt_reg <= SWS_FLT_IDLE; // see R1
      hold_cnt_reg <= 6'h00;
      halt_d_reg <= 1'b0;
      idle_d_reg <= 1'b0;
      cm_cnt_reg <= 16'h0000;
      cm_err_reg <= 1'b0;
      cm_hold_reg <= 1'b0;
      cm_hcnt_reg <= 6'h00;
      drive_reg <= 1'b0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      win_reg <= win_next;
      cm_en_reg <= cm_en_next;
      cfg_reg <= cfg_next;
      clk_delay_reg <= clk_delay_next;
      pend_reg <= pend_next;
      wd_cnt_reg <= wd_cnt_next;
      first_win_reg <= first_win_next;
      flt_reg <= flt_next;
      hold_cnt_reg <= hold_cnt_next;
      halt_d_reg <= halt_d_next;
      idle_d_reg <= idle_d_next;
      cm_cnt_reg <= cm_cnt_next;
      cm_err_reg <= cm_err_next;
      cm_hold_reg <= cm_hold_next;
      cm_hcnt_reg <= cm_hcnt_next;
      drive_reg <= drive_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  // Outputs straight from flip-flops; the pin value is always low when enabled.
  // The pin value is a tie: the enable alone chooses between driving low and
  // leaving the pin to the external pull-up.
  always_comb begin
    fault_pin_o = 1'b0;
    fault_pin_oe_n_o = ~drive_reg; // see R9
    prdata_o = prdata_reg;
    pready_o = pready_reg;
    pslverr_o = pslverr_reg;
  end

endmodule // sws_supervisor

// *** verif/sws_supervisor_assertions.sv ***
// Port checker for the service window supervisor.
module sws_supervisor_assertions
  import sws_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic inst_tick_i,
  input wire logic fault_pin_i,
  input wire logic fault_pin_o,
  input wire logic fault_pin_oe_n_o,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] hold_reg;
  logic [7:0] hold_next;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  // Counts instruction ticks while the pin is driven and seen low.
  always_comb begin
    hold_next = hold_reg;
    if (fault_pin_oe_n_o)
      hold_next = 8'h00;
    else if (inst_tick_i && !fault_pin_i && hold_reg != 8'hFF)
      hold_next = hold_reg + 8'h01;
  end
  // Registers the tick count.
  always_ff @(posedge mclk_i) begin
    if (reset_i)
      hold_reg <= 8'h00;
    else
      hold_reg <= hold_next;
  end
  a_reset_quiet: assert property (disable iff (1'b0) reset_i |=> fault_pin_oe_n_o && !pready_o)
    else $error("outputs active during reset");
  a_pin_low_only: assert property (fault_pin_o == 1'b0)
    else $error("fault pin drives high");
  a_ready_wait: assert property (psel_i && !penable_i |=> !pready_o ##1 pready_o)
    else $error("ready not after one wait state");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_key_hidden: assert property (pready_o && !pwrite_i && paddr_i == SWS_SVC_OFS |-> prdata_o[5:1] == 5'h00)
    else $error("key field readable");
  a_unmapped_err: assert property (pready_o && paddr_i > SWS_STAT_OFS |-> pslverr_o)
    else $error("unmapped access not refused");
  a_hold_early: assert property (!fault_pin_oe_n_o && !fault_pin_i && hold_reg < 8'h0F |=> !fault_pin_oe_n_o)
    else $error("pin released too soon");
  a_hold_range: assert property ($rose(fault_pin_oe_n_o) |-> hold_reg >= 8'h10 && hold_reg <= 8'h21)
    else $error("pin hold out of range");
  // Main scenarios reached.
  c_drive: cover property ($fell(fault_pin_oe_n_o));
  c_release: cover property ($rose(fault_pin_oe_n_o));
  c_refused: cover property (pslverr_o);
endmodule // sws_supervisor_assertions

bind sws_supervisor sws_supervisor_assertions u_sws_supervisor_assertions (
  .mclk_i, .reset_i, .inst_tick_i, .fault_pin_i, .fault_pin_o, .fault_pin_oe_n_o,
  .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o);

// *** verif/sws_pin_model.sv ***
// Pull-up and reset circuit model on the open-drain fault pin.
module sws_pin_model (
  input wire logic mclk_i,
  input wire logic slow_i,
  input wire logic pin_o_i,
  input wire logic pin_oe_n_i,
  output logic pin_level_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lag_reg;
  logic level;
  // The resistor pulls the pin high unless the low driver is enabled.
  assign level = pin_oe_n_i ? 1'b1 : pin_o_i;
  // A slow edge reaches the sense input one cycle late.
  always_ff @(posedge mclk_i) begin
    lag_reg <= level;
  end
  assign pin_level_o = slow_i ? lag_reg : level;
endmodule // sws_pin_model

// *** verif/tb_service_window_supervisor.sv ***
// Self-checking bench for the service window supervisor.
module tb_service_window_supervisor;
  import sws_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 0, reset_i = 1, tick = 1, rtick = 0, halt = 0, idle = 0, slow = 0, rco = 0;
  logic psel = 0, pen = 0, pwr = 0, pin, pin_o, oe_n, pready, perr, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int n_mismatch = 0, num_checks = 0, rdiv = 0;
  // Clock of 40 ns period.
  always #20 mclk_i = ~mclk_i;
  // Reference tick every 50 cycles.
  always @(posedge mclk_i) begin
    rdiv <= (rdiv == 49) ? 0 : rdiv + 1;
    rtick <= (rdiv == 49);
  end
  sws_supervisor #(.REF_TICK_HZ(100)) u_sws_supervisor (
    .mclk_i, .reset_i, .inst_tick_i(tick), .ref_tick_i(rtick), .halt_i(halt), .idle_i(idle),
    .rc_osc_opt_i(rco), .fault_pin_i(pin), .fault_pin_o(pin_o), .fault_pin_oe_n_o(oe_n),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr));
  sws_pin_model u_sws_pin_model (.mclk_i, .slow_i(slow), .pin_o_i(pin_o), .pin_oe_n_i(oe_n), .pin_level_o(pin));
  // Prints the counts and the verdict.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Compares one value and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // One APB transfer, held until ready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int c;
    @(posedge mclk_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    pen <= 1'b1;
    c = 0;
    do begin
      @(posedge mclk_i);
      c++;
      if (c > 20) begin
        chk(32'(pready), 32'h1);
        end_sim();
      end
    end while (pready !== 1'b1);
    r = prdata;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd);
  endtask
  // Waits a bounded time for the pin enable to reach a level.
  task automatic wait_oe(input logic v, input int lim, output int c);
    c = 0;
    while (oe_n !== v) begin
      @(posedge mclk_i);
      c++;
      if (c > lim) begin
        chk(32'(oe_n), 32'(v));
        end_sim();
      end
    end
  endtask
  // Expects the pin driven, then released after the hold time.
  task automatic fault(input int lim);
    int c;
    wait_oe(1'b0, lim, c);
    wait_oe(1'b1, 60, c);
    chk(32'(c >= 16 && c <= 35), 32'h1);
  endtask
  // Reset values, registers, refusal and an early first configuration.
  task automatic t_reset_cfg();
    apb(1'b0, SWS_SVC_OFS, 32'h0, rd);
    chk(rd, 32'h000000C1);
    wr(SWS_CTRL_OFS, 32'h1);
    apb(1'b0, SWS_CTRL_OFS, 32'h0, rd);
    chk(rd, 32'h00000001);
    apb(1'b0, 8'h40, 32'h0, rd);
    chk(32'(e), 32'h1);
    wr(SWS_CTRL_OFS, 32'h0);
    wr(SWS_SVC_OFS, 32'h19);
    wt(50);
    chk(32'(oe_n), 32'h1);
    apb(1'b0, SWS_SVC_OFS, 32'h0, rd);
    chk(rd, 32'h00000001);
  endtask
  // Early service, an in-window one, then a missed deadline.
  task automatic t_window();
    wr(SWS_SVC_OFS, 32'h19);
    fault(10);
    wt(2100);
    wr(SWS_SVC_OFS, 32'h19);
    wt(8000);
    chk(32'(oe_n), 32'h1);
    fault(200);
  endtask
  // Each single-field mismatch faults, with a slow pin edge.
  task automatic t_mismatch();
    logic [31:0] bad [3] = '{32'hD9, 32'h1B, 32'h18};
    slow <= 1'b1;
    foreach (bad[i]) begin
      wt(2100);
      wr(SWS_SVC_OFS, bad[i]);
      fault(10);
    end
    slow <= 1'b0;
  endtask
  // Leaving idle services the window, so a write at once is early.
  task automatic t_idle();
    wt(2100);
    idle <= 1'b1;
    wt(40);
    idle <= 1'b0;
    wr(SWS_SVC_OFS, 32'h19);
    fault(10);
  endtask
  // A halted instruction clock trips the monitor until ticks return.
  task automatic t_clock();
    int c;
    halt <= 1'b1;
    tick <= 1'b0;
    wait_oe(1'b0, 400, c);
    wt(100);
    chk(32'(oe_n), 32'h0);
    halt <= 1'b0;
    tick <= 1'b1;
    wait_oe(1'b1, 60, c);
    chk(32'(c >= 16 && c <= 35), 32'h1);
  endtask
  // The idle timer flag is set by now and clears by software.
  task automatic t_pend();
    apb(1'b0, SWS_STAT_OFS, 32'h0, rd);
    chk(rd & 32'h1, 32'h1);
    wr(SWS_STAT_OFS, 32'h1);
    apb(1'b0, SWS_STAT_OFS, 32'h0, rd);
    chk(rd & 32'h1, 32'h0);
  endtask
  // With the RC option and no delay, halt pauses the window and it resumes on exit.
  task automatic t_halt();
    wt(2100);
    rco <= 1'b1;
    wr(SWS_SVC_OFS, 32'h19);
    wt(4000);
    halt <= 1'b1;
    wt(60);
    halt <= 1'b0;
    wt(4140);
    chk(32'(oe_n), 32'h1);
    fault(100);
    rco <= 1'b0;
  endtask
  // Reset for six cycles, run the scenarios, then report.
  initial begin
    wt(6);
    reset_i <= 1'b0;
    t_reset_cfg();
    t_window();
    t_mismatch();
    t_idle();
    t_clock();
    t_pend();
    t_halt();
    end_sim();
  end
endmodule // tb_service_window_supervisor
